//--- verilog/synth_load_regs.svh
// Offsets, field positions and reset values of the serial load port
`ifndef SYNTH_LOAD_REGS_SVH
`define SYNTH_LOAD_REGS_SVH

`define WORD_W 24
`define SEL_HI 1
`define SEL_LO 0
`define SEL_CTRL 2'h0
`define SEL_RCNT 2'h1
`define SEL_NCNT 2'h2
`define SEL_TEST 2'h3
`define LATCH_CNT 4
`define CTRL_PD_BIT 20
`define CTRL_MON_HI 7
`define CTRL_MON_LO 5
`define LATCH_RESET 24'h00_0000

`endif

//--- verilog/synth_load_pkg.sv
// Types shared by the serial load port and its latch bank
`include "synth_load_regs.svh"

package synth_load_pkg;

    typedef logic [`WORD_W-1:0] word_t;

    // Index order follows the latch-select code: ctrl is entry 0
    typedef struct packed {
        word_t test;
        word_t ncnt;
        word_t rcnt;
        word_t ctrl;
    } latch_set_t;

    typedef enum logic [2:0] {
        MON_LOW = 3'h0,
        MON_LOCK = 3'h1,
        MON_RF = 3'h2,
        MON_REF = 3'h4
    } mon_sel_t;

    typedef struct packed {
        word_t shift;
    } link_state_t;

    typedef struct packed {
        logic strobe_meta;
        logic strobe_sync;
        logic strobe_prev;
        logic ce_meta;
        logic ce_sync;
        logic [2:0] mon_meta;
        logic [2:0] mon_sync;
        logic pump;
        logic pump_oe;
        logic pd;
        logic mon_out;
    } sys_state_t;

    typedef struct packed {
        word_t [`LATCH_CNT-1:0] q;
        logic [`LATCH_CNT-1:0] written;
    } bank_state_t;

endpackage

//--- verilog/latch_bank.sv
// Four configuration latches loaded from the shift word
`timescale 1ns/1ps
`default_nettype none
`include "synth_load_regs.svh"

module latch_bank
    import synth_load_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic wr_en_i,
    input wire word_t wr_data_i,
    output var latch_set_t q_o,
    output logic [`LATCH_CNT-1:0] written_o
);
    bank_state_t s;
    bank_state_t next_s;
    logic [`LATCH_CNT-1:0] hit;

    // Exactly one latch matches any select code
    for (genvar gi = 0; gi < `LATCH_CNT; gi++) begin : g_hit
        assign hit[gi] = wr_en_i &&
            (wr_data_i[`SEL_HI:`SEL_LO] == 2'(gi)); // [R3] [R8] [R4]
    end

    always_comb begin
        next_s = s;
        next_s.written = hit;
        for (int i = 0; i < `LATCH_CNT; i++) begin
            if (hit[i]) begin
                next_s.q[i] = wr_data_i; // [R4]
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '{q: {`LATCH_CNT{`LATCH_RESET}}, written: 4'h0};
        end else if (clk_en_i) begin
            s <= next_s; // [R10]
        end
    end

    assign q_o = latch_set_t'(s.q);
    assign written_o = s.written;

    a_store_word: assert property ( // [R4]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && wr_en_i
        |=> s.q[$past(wr_data_i[`SEL_HI:`SEL_LO])] == $past(wr_data_i))
        else $error("loaded latch does not hold the shifted word");

    a_hold_latch: assert property ( // [R10]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !(clk_en_i && wr_en_i)
        |=> $stable(s.q))
        else $error("latch changed without a load");

endmodule
`default_nettype wire

//--- verilog/synth_serial_load_port.sv
// Serial configuration load port of a frequency synthesizer
// Behaviour
// (R1) Each serial clock rising edge shifts data into the 24-bit register.
// (R2) Host sends each word most significant bit first.
// (R3) Two lowest bits select the latch; upper bits are its payload.
// (R4) Load strobe rising copies the word into the one selected latch.
// (R5) Chip enable low: powered down, charge pump output three-stated. Code does this only while clk_en_i is high; otherwise both hold.
// (R6) Chip enable high powers up only as power-down bits allow.
// (R7) Monitor output shows lock detect, divided RF or divided reference.
// (R8) Select 00 control, 01 R counter, 10 N counter, 11 test.
// (R9) Host writes R counter, control, then N; never the test latch.
// (R10) Latches hold until a matching load; shifting never changes them.
`timescale 1ns/1ps
`default_nettype none
`include "synth_load_regs.svh"

module synth_serial_load_port
    import synth_load_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_i,
    input wire logic load_strobe_i,
    input wire logic chip_enable_i,
    input wire logic lock_detect_i,
    input wire logic rf_div_i,
    input wire logic ref_div_i,
    input wire logic pump_drive_i,
    output logic monitor_output_o,
    output logic charge_pump_output_o,
    output logic charge_pump_output_oe_o,
    output logic powered_down_o,
    output var latch_set_t latches_o,
    output logic [`LATCH_CNT-1:0] latch_written_o
);
    link_state_t link;
    link_state_t next_link;
    sys_state_t s;
    sys_state_t next_s;
    logic load_rise;
    mon_sel_t mon_sel;
    logic [`WORD_W-2:0] shift_body;
    logic [1:0] shift_sel;

    // Link side: runs only while the host toggles the serial clock
    always_comb begin
        next_link = link;
        next_link.shift = {link.shift[`WORD_W-2:0], serial_data_i}; // [R1] [R2]
    end

    always_ff @(posedge serial_clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link <= '{shift: `LATCH_RESET};
        end else begin
            link <= next_link; // [R1]
        end
    end

    assign shift_body = link.shift[`WORD_W-2:0];
    assign shift_sel = link.shift[`SEL_HI:`SEL_LO];

    // The shift word is read across domains only on a synchronised strobe
    // edge; the host keeps the serial clock idle around the strobe, so the
    // word is stable for the two synchroniser cycles.
    assign load_rise = s.strobe_sync && !s.strobe_prev; // [R4]

    latch_bank u_bank (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .wr_en_i(load_rise),
        .wr_data_i(link.shift),
        .q_o(latches_o),
        .written_o(latch_written_o)
    );

    assign mon_sel = mon_sel_t'(latches_o.ctrl[`CTRL_MON_HI:`CTRL_MON_LO]);

    always_comb begin
        next_s = s;
        // Two flops per pin, plus a third strobe flop for edge detect; the first flop feeds no logic
        next_s.strobe_meta = load_strobe_i;
        next_s.strobe_sync = s.strobe_meta;
        next_s.strobe_prev = s.strobe_sync;
        next_s.ce_meta = chip_enable_i;
        next_s.ce_sync = s.ce_meta;
        next_s.mon_meta = {ref_div_i, rf_div_i, lock_detect_i};
        next_s.mon_sync = s.mon_meta;
        // Drive comes from logic on this clock, so no synchroniser
        next_s.pump = pump_drive_i;
        // Chip enable low forces power-down whenever clk_en_i is high; with chip enable high the power-down bit still rules
        next_s.pd = !s.ce_sync || latches_o.ctrl[`CTRL_PD_BIT]; // [R5] [R6]
        next_s.pump_oe = !next_s.pd; // [R5]
        case (mon_sel)
            MON_LOCK: next_s.mon_out = s.mon_sync[0]; // [R7]
            MON_RF: next_s.mon_out = s.mon_sync[1]; // [R7]
            MON_REF: next_s.mon_out = s.mon_sync[2]; // [R7]
            default: next_s.mon_out = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '{pd: 1'b1, default: '0};
        end else if (clk_en_i) begin
            s <= next_s;
        end
    end

    assign monitor_output_o = s.mon_out;
    assign charge_pump_output_o = s.pump;
    assign charge_pump_output_oe_o = s.pump_oe;
    assign powered_down_o = s.pd;

    // Link domain: one bit in per serial clock edge
    a_shift_msb_in: assert property ( // [R1]
        @(posedge serial_clock_i) disable iff (!rst_n_i)
        1'b1
        |=> link.shift == {$past(shift_body), $past(serial_data_i)})
        else $error("shift register did not take the data bit");

    // System domain
    a_load_select: assert property ( // [R4] [R8]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && load_rise
        |=> latch_written_o == (4'h1 << $past(shift_sel)))
        else $error("strobe did not load exactly the selected latch");

    a_one_latch: assert property ( // [R4]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $onehot0(latch_written_o))
        else $error("more than one latch loaded at once");

    a_load_once: assert property ( // [R4]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && load_rise
        |=> !load_rise)
        else $error("held strobe loaded more than once");

    a_shift_no_load: assert property ( // [R10]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !load_rise ##1 !load_rise
        |-> $stable(latches_o) && latch_written_o == 4'h0)
        else $error("latches changed without a strobe");

    a_ctrl_payload: assert property ( // [R3]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && load_rise && shift_sel == `SEL_CTRL
        |=> latches_o.ctrl == $past(link.shift))
        else $error("control latch payload mismatch");

    a_ce_tristate: assert property ( // [R5]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && !s.ce_sync
        |=> powered_down_o && !charge_pump_output_oe_o)
        else $error("charge pump driven while chip enable is low");

    a_ce_latency: assert property ( // [R5]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && !s.ce_meta ##1 clk_en_i
        |=> powered_down_o)
        else $error("power-down late after chip enable fell");

    a_pd_bit_holds: assert property ( // [R6]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && s.ce_sync && latches_o.ctrl[`CTRL_PD_BIT]
        |=> powered_down_o)
        else $error("powered up against the power-down bit");

    a_power_up: assert property ( // [R6]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && s.ce_sync && !latches_o.ctrl[`CTRL_PD_BIT]
        |=> !powered_down_o && charge_pump_output_oe_o)
        else $error("did not power up with enable high");

    // Monitor follows its source three edges after the pin
    a_mon_lock: assert property ( // [R7]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && mon_sel == MON_LOCK
        |=> monitor_output_o == $past(s.mon_sync[0]))
        else $error("monitor output does not show lock detect");

    a_mon_rf: assert property ( // [R7]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && mon_sel == MON_RF
        |=> monitor_output_o == $past(s.mon_sync[1]))
        else $error("monitor output does not show divided RF");

    a_mon_ref: assert property ( // [R7]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && mon_sel == MON_REF
        |=> monitor_output_o == $past(s.mon_sync[2]))
        else $error("monitor output does not show divided reference");

    a_mon_off: assert property ( // [R7]
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && !(mon_sel inside {MON_LOCK, MON_RF, MON_REF})
        |=> !monitor_output_o)
        else $error("monitor output not low for an unused code");

    // Main scenarios
    c_load_ncnt: cover property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        load_rise && shift_sel == `SEL_NCNT);

    c_load_rcnt: cover property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        load_rise && shift_sel == `SEL_RCNT);

    c_chip_off: cover property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        s.ce_sync ##1 !s.ce_sync);

    c_mon_ref: cover property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        mon_sel == MON_REF && monitor_output_o);

    c_pd_by_bit: cover property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        s.ce_sync && latches_o.ctrl[`CTRL_PD_BIT] && powered_down_o);

endmodule
`default_nettype wire

//--- sim/host_serial_model.sv
// Host side model that shifts words into the serial load port
`timescale 1ns/1ps
`default_nettype none
module host_serial_model;
    logic serial_clock_o = 1'b0;
    logic serial_data_o = 1'b0;
    logic load_strobe_o = 1'b0;
    // Clock idles low between frames; data scrambled once hold expires
    task automatic shift(input logic [31:0] v, input int n, input bit ld);
        for (int k = n - 1; k >= 0; k--) begin
            serial_data_o = v[k];
            #24 serial_clock_o = 1'b1;
            #14 serial_data_o = ~v[k];
            #10 serial_clock_o = 1'b0;
        end
        if (ld) begin
            // Strobe held long enough for the two-flop synchroniser
            #20 load_strobe_o = 1'b1;
            #40 load_strobe_o = 1'b0;
            #60;
        end
    endtask
endmodule
`default_nettype wire

//--- sim/synth_serial_load_port_tb.sv
// Self-checking bench for the serial load port
`timescale 1ns/1ps
`default_nettype none
module synth_serial_load_port_tb;
    import synth_load_pkg::*;
    logic clk_sys_i, rst_n_i, en, ce, lock, rf, rfd, cpd, mon, pump, oe, pd;
    latch_set_t lat, e;
    logic [3:0] wr, wr_last;
    int n_wr = 0;
    int n_fail = 0;
    int checks_done = 0;
    host_serial_model i_host();
    synth_serial_load_port i_dut(.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .clk_en_i(en), .serial_clock_i(i_host.serial_clock_o),
        .serial_data_i(i_host.serial_data_o),
        .load_strobe_i(i_host.load_strobe_o), .chip_enable_i(ce),
        .lock_detect_i(lock), .rf_div_i(rf), .ref_div_i(rfd),
        .pump_drive_i(cpd), .monitor_output_o(mon),
        .charge_pump_output_o(pump), .charge_pump_output_oe_o(oe),
        .powered_down_o(pd), .latches_o(lat), .latch_written_o(wr));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Counting pulses catches a missing or doubled load pulse
    always @(posedge clk_sys_i) begin
        if (|wr) begin
            wr_last <= wr;
            n_wr <= n_wr + 1;
        end
    end
    task automatic chk(input logic [95:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic load(input word_t w, input logic [3:0] ew);
        int n0;
        n0 = n_wr;
        i_host.shift({8'h00, w}, 24, 1'b1);
        chk(n_wr - n0, 1, "one written pulse");
        chk(wr_last, ew, "written pulse");
        cyc(1);
    endtask
    task automatic t_reset;
        chk({pd, oe, pump, mon}, 4'b1000, "reset outputs");
        chk(lat, '0, "reset latches");
        $display("test reset done");
    endtask
    task automatic t_order;
        e = '0;
        // Power-up write order: R counter, control, N counter
        load(24'h12_3455, 4'h2);
        e.rcnt = 24'h12_3455;
        chk(lat, e, "rcnt load");
        load(24'h00_0020, 4'h1);
        e.ctrl = 24'h00_0020;
        chk(lat, e, "ctrl load");
        load(24'hab_cde6, 4'h4);
        e.ncnt = 24'hab_cde6;
        chk(lat, e, "ncnt load");
        $display("test order done");
    endtask
    task automatic t_shift;
        i_host.shift(32'h5a5a_5a5a, 28, 1'b0);
        cyc(4);
        chk(lat, e, "shift only");
        i_host.shift(32'h0, 0, 1'b1);
        cyc(1);
        e.ncnt = 24'h5a_5a5a;
        chk(lat, e, "last 24 bits");
        $display("test shift done");
    endtask
    task automatic t_power;
        ce = 1'b1;
        cpd = 1'b1;
        cyc(6);
        chk({pd, oe, pump}, 3'b011, "power up");
        cpd = 1'b0;
        cyc(2);
        chk(pump, 1'b0, "pump follows drive");
        ce = 1'b0;
        cyc(6);
        chk({pd, oe}, 2'b10, "chip disable");
        ce = 1'b1;
        load(24'h10_0020, 4'h1);
        cyc(4);
        chk({pd, oe}, 2'b10, "pd bit set");
        load(24'h00_0020, 4'h1);
        cyc(4);
        chk({pd, oe}, 2'b01, "pd bit clear");
        en = 1'b0;
        ce = 1'b0;
        cyc(6);
        chk({pd, oe}, 2'b01, "frozen by clock enable");
        en = 1'b1;
        cyc(6);
        chk({pd, oe}, 2'b10, "chip disable after thaw");
        ce = 1'b1;
        $display("test power done");
    endtask
    task automatic t_monitor;
        logic [2:0] codes [3] = '{3'h1, 3'h2, 3'h4};
        foreach (codes[i]) begin
            load({16'h0000, codes[i], 5'h00}, 4'h1);
            {rfd, rf, lock} = codes[i];
            cyc(6);
            chk(mon, 1'b1, "monitor high");
            {rfd, rf, lock} = ~codes[i];
            cyc(6);
            chk(mon, 1'b0, "monitor low");
        end
        load(24'h00_0000, 4'h1);
        {rfd, rf, lock} = 3'h7;
        cyc(6);
        chk(mon, 1'b0, "monitor off code");
        $display("test monitor done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        report_and_stop;
    end
    initial begin
        {rst_n_i, ce, lock, rf, rfd, cpd} = '0;
        en = 1'b1;
        cyc(3);
        rst_n_i = 1'b1;
        cyc(2);
        t_reset;
        t_order;
        t_shift;
        t_power;
        t_monitor;
        report_and_stop;
    end
endmodule
`default_nettype wire
